// >>> core/rfo_converter.sv
// counting and sequencing core of one resistance-to-frequency converter channel
// assumes osc and time base clocks arrive as levels synchronous to mclk, no faster than mclk/2
//
// Summary of operation
// (RULE_01) measurement counter is 24-bit, counts up on osc clock, software presettable
// (RULE_02) time base counter is 24-bit, presettable, counts up during reference oscillation
// (RULE_03) during sensor oscillation time base counts down, ends oscillation at zero
// (RULE_04) writing reference start begins reference run, time base starts from zero
// (RULE_05) either counter wrapping during reference run clears its start bit and stops
// (RULE_06) measurement wrap in reference run sets reference done flag
// (RULE_07) time base wrap in reference run sets time base overflow flag
// (RULE_08) writing a sensor start begins sensor run, measurement counter starts at zero
// (RULE_09) sensor run stops at time base zero or measurement wrap, clearing its start bit
// (RULE_10) time base zero sets done flag of the active sensor
// (RULE_11) measurement wrap in sensor run sets measurement overflow flag
// (RULE_12) writing zero to the running start bit aborts, counters hold their values
// (RULE_13) free run ignores all automatic stops until software clears the start bit
// (RULE_14) monitor pin carries osc clock while converting, halved when selected
// (RULE_15) measurement counter follows osc clock, time base counter follows time base clock
// (RULE_16) software presets measurement counter and zeroes time base before reference run
// (RULE_17) software clears the relevant flags by writing one before each run
// (RULE_18) in AC mode software uses sensor A start, not sensor B
// (RULE_19) software reads running counters twice and accepts matching values
// (RULE_20) after an abort software reinitialises counters before a new run
// (RULE_21) software may save and restore time base count to skip reference runs
// (RULE_22) interrupt request only for a set flag whose enable is one
// (RULE_23) in AC mode a sensor B start write is ignored
// (RULE_24) start bits read one while their oscillation runs, zero when stopped
// (RULE_25) channel runs only while block enable is one, clearing it halts conversion
// (RULE_26) only one oscillation at a time, starts during an active run are ignored
`timescale 1ns/10ps
module rfo_converter
  import rfo_pkg::*;
#(
  parameter int CNT_W = `RFO_CNT_W
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic [`RFO_ADDR_W-1:0]  busAddr,
  input  wire logic [`RFO_DATA_W-1:0]  busWdata,
  input  wire logic                    busWr,
  input  wire logic                    busRd,
  output logic      [`RFO_DATA_W-1:0]  busRdata,
  input  wire logic                    oscClk,
  input  wire logic                    timebaseClk,
  output logic                         monitorOutPin,
  output logic                         irqReq,
  output logic                         blockEnable
);

  // the struct and register split only serve a 24-bit counter
  if (CNT_W != `RFO_CNT_W) begin : g_chk
    $error("rfo_converter: CNT_W must equal 24");
  end

  localparam rfo_cnt_t CNT_MAX = '1;
  localparam rfo_cnt_t CNT_ONE = 24'h000001;

  rfo_state_s s_r;
  rfo_state_s s_nxt;
  logic       oscRise;
  logic       tbRise;
  logic       running;
  logic       mcWrap;
  logic       tcWrap;
  logic       tcZero;
  logic [`RFO_NFLAG-1:0] evSet;
  logic [`RFO_NFLAG-1:0] evClr;
  logic       trgWr;

  // read multiplexer for the register port
  function automatic logic [`RFO_DATA_W-1:0] regRead(input rfo_state_s s,
                                                     input logic [`RFO_ADDR_W-1:0] a);
    logic [`RFO_DATA_W-1:0] d;
    d = 16'h0000;
    case (a)
      `RFO_CTL_IDX:
      begin
        d[`RFO_CTL_EN_BIT] = s.blockEn;
        d[`RFO_CTL_MODE_LSB +: 2] = s.oscMode;
        d[`RFO_CTL_FREE_BIT] = s.freeRun;
        d[`RFO_CTL_HALF_BIT] = s.monHalve;
      end
      `RFO_TRG_IDX:
      begin
        d[`RFO_TRG_REF_BIT] = (s.mode == OSC_REF); // RULE_24
        d[`RFO_TRG_SNA_BIT] = (s.mode == OSC_SNA); // RULE_24
        d[`RFO_TRG_SNB_BIT] = (s.mode == OSC_SNB); // RULE_24
      end
      `RFO_FLAG_IDX: d[`RFO_NFLAG-1:0] = s.flags;
      `RFO_EN_IDX:   d[`RFO_NFLAG-1:0] = s.en;
      `RFO_MCL_IDX:  d = s.mc[15:0];
      `RFO_MCH_IDX:  d[7:0] = s.mc[23:16];
      `RFO_TBL_IDX:  d = s.tc[15:0];
      `RFO_TBH_IDX:  d[7:0] = s.tc[23:16];
      default:       d = 16'h0000;
    endcase
    return d;
  endfunction

  // edge enables of the two counting clocks and stop events
  assign oscRise = oscClk & ~s_r.oscPrev; // RULE_15
  assign tbRise  = timebaseClk & ~s_r.tbPrev; // RULE_15
  assign running = (s_r.mode != OSC_IDLE) && s_r.blockEn;
  assign mcWrap  = running && oscRise && (s_r.mc == CNT_MAX);
  assign tcWrap  = running && (s_r.mode == OSC_REF) && tbRise && (s_r.tc == CNT_MAX);
  assign tcZero  = running && (s_r.mode != OSC_REF) && tbRise && (s_r.tc == CNT_ONE);
  assign trgWr   = busWr && (busAddr == `RFO_TRG_IDX);
  assign evClr   = (busWr && busAddr == `RFO_FLAG_IDX) ? busWdata[`RFO_NFLAG-1:0] : 5'h00;

  // hardware flag events, one bit per termination cause
  always_comb
  begin
    evSet = `RFO_FLAG_RST;
    evSet[`RFO_F_REF]  = (s_r.mode == OSC_REF) && mcWrap; // RULE_06
    evSet[`RFO_F_TOVF] = tcWrap; // RULE_07
    evSet[`RFO_F_SNA]  = (s_r.mode == OSC_SNA) && tcZero; // RULE_10
    evSet[`RFO_F_SNB]  = (s_r.mode == OSC_SNB) && tcZero; // RULE_10
    evSet[`RFO_F_MOVF] = (s_r.mode != OSC_REF) && mcWrap; // RULE_11
    // a free run never ends by itself, so no termination flag is raised
    if (s_r.freeRun)
      evSet = `RFO_FLAG_RST; // RULE_13
  end

  // next state: counting, automatic stop, register writes, trigger control
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.oscPrev = oscClk;
    s_nxt.tbPrev  = timebaseClk;
    if (running)
    begin
      if (oscRise)
        s_nxt.mc = s_r.mc + CNT_ONE; // RULE_01
      if (tbRise && s_r.mode == OSC_REF)
        s_nxt.tc = s_r.tc + CNT_ONE; // RULE_02
      else if (tbRise)
        s_nxt.tc = s_r.tc - CNT_ONE; // RULE_03
      if (!s_r.freeRun && (mcWrap || tcWrap || tcZero)) // RULE_13
        s_nxt.mode = OSC_IDLE; // RULE_05 RULE_09
    end
    // set wins over a clear in the same cycle
    s_nxt.flags = (s_r.flags & ~evClr) | evSet;
    if (busWr)
    begin
      case (busAddr)
        `RFO_CTL_IDX:
        begin
          s_nxt.blockEn  = busWdata[`RFO_CTL_EN_BIT];
          s_nxt.oscMode  = busWdata[`RFO_CTL_MODE_LSB +: 2];
          s_nxt.freeRun  = busWdata[`RFO_CTL_FREE_BIT];
          s_nxt.monHalve = busWdata[`RFO_CTL_HALF_BIT];
        end
        `RFO_EN_IDX:  s_nxt.en = busWdata[`RFO_NFLAG-1:0];
        `RFO_MCL_IDX: s_nxt.mc[15:0] = busWdata; // RULE_01
        `RFO_MCH_IDX: s_nxt.mc[23:16] = busWdata[7:0]; // RULE_01
        `RFO_TBL_IDX: s_nxt.tc[15:0] = busWdata; // RULE_02
        `RFO_TBH_IDX: s_nxt.tc[23:16] = busWdata[7:0]; // RULE_02
        default: ;
      endcase
    end
    // start only from idle, abort only through the running start bit
    if (trgWr && s_r.mode == OSC_IDLE && s_r.blockEn) // RULE_26
    begin
      if (busWdata[`RFO_TRG_REF_BIT])
      begin
        s_nxt.mode = OSC_REF; // RULE_04
        s_nxt.tc   = `RFO_CNT_RST; // RULE_04
      end
      else if (busWdata[`RFO_TRG_SNA_BIT])
      begin
        s_nxt.mode = OSC_SNA; // RULE_08
        s_nxt.mc   = `RFO_CNT_RST; // RULE_08
      end
      else if (busWdata[`RFO_TRG_SNB_BIT] && s_r.oscMode != `RFO_MODE_AC) // RULE_23
      begin
        s_nxt.mode = OSC_SNB; // RULE_08
        s_nxt.mc   = `RFO_CNT_RST; // RULE_08
      end
    end
    else if (trgWr && s_r.mode != OSC_IDLE)
    begin
      if ((s_r.mode == OSC_REF && !busWdata[`RFO_TRG_REF_BIT]) ||
          (s_r.mode == OSC_SNA && !busWdata[`RFO_TRG_SNA_BIT]) ||
          (s_r.mode == OSC_SNB && !busWdata[`RFO_TRG_SNB_BIT]))
        s_nxt.mode = OSC_IDLE; // RULE_12
    end
    if (!s_nxt.blockEn)
      s_nxt.mode = OSC_IDLE; // RULE_25
    // monitor output and its divide-by-two stage
    if (s_nxt.mode == OSC_IDLE)
      s_nxt.monDiv = 1'b0;
    else if (oscRise)
      s_nxt.monDiv = ~s_r.monDiv;
    s_nxt.monOut = (s_nxt.mode != OSC_IDLE) &&
                   (s_r.monHalve ? s_nxt.monDiv : oscClk); // RULE_14
    s_nxt.irq = |(s_nxt.flags & s_nxt.en); // RULE_22
    s_nxt.rdata = busRd ? regRead(s_r, busAddr) : 16'h0000;
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '{mode: OSC_IDLE, mc: `RFO_CNT_RST, tc: `RFO_CNT_RST, flags: `RFO_FLAG_RST,
               en: `RFO_FLAG_RST, oscMode: 2'h0, rdata: 16'h0000, default: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign busRdata      = s_r.rdata;
  assign monitorOutPin = s_r.monOut;
  assign irqReq        = s_r.irq;
  assign blockEnable   = s_r.blockEn;

  // checks on sequencing and flags
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  ref_start_a: assert property ( // RULE_04
    trgWr && busWdata[`RFO_TRG_REF_BIT] && s_r.mode == OSC_IDLE && s_r.blockEn &&
    busWdata[`RFO_CTL_EN_BIT] |=> s_r.mode == OSC_REF && s_r.tc == 24'h000000)
    else $error("reference start not taken");
  sensb_ac_a: assert property ( // RULE_23
    trgWr && busWdata[2:0] == 3'h4 && s_r.mode == OSC_IDLE && s_r.oscMode == `RFO_MODE_AC
    |=> s_r.mode == OSC_IDLE)
    else $error("sensor B started in AC mode");
  ref_done_a: assert property ( // RULE_06
    s_r.mode == OSC_REF && running && oscRise && s_r.mc == 24'hffffff && !s_r.freeRun
    |=> s_r.flags[`RFO_F_REF] && s_r.mode == OSC_IDLE && s_r.mc == 24'h000000)
    else $error("reference completion missing");
  tb_ovf_a: assert property ( // RULE_07
    s_r.mode == OSC_REF && running && tbRise && s_r.tc == 24'hffffff && !s_r.freeRun
    |=> s_r.flags[`RFO_F_TOVF] && s_r.mode == OSC_IDLE)
    else $error("time base overflow missing");
  sens_done_a: assert property ( // RULE_10
    s_r.mode == OSC_SNA && running && tbRise && s_r.tc == 24'h000001 && !s_r.freeRun
    |=> s_r.flags[`RFO_F_SNA] && s_r.tc == 24'h000000 && s_r.mode == OSC_IDLE)
    else $error("sensor A completion missing");
  meas_ovf_a: assert property ( // RULE_11
    (s_r.mode == OSC_SNA || s_r.mode == OSC_SNB) && running && oscRise &&
    s_r.mc == 24'hffffff && !s_r.freeRun |=> s_r.flags[`RFO_F_MOVF])
    else $error("measurement overflow missing");
  abort_hold_a: assert property ( // RULE_12
    s_r.mode == OSC_REF && trgWr && !busWdata[`RFO_TRG_REF_BIT]
    |=> s_r.mode == OSC_IDLE ##1 ($past(busWr) || $stable(s_r.mc)))
    else $error("abort did not stop and hold");
  free_run_a: assert property ( // RULE_13
    s_r.freeRun && running && !busWr |=> s_r.mode == $past(s_r.mode))
    else $error("free run stopped by itself");
  irq_gate_a: assert property ( // RULE_22
    irqReq == |(s_r.flags & s_r.en))
    else $error("interrupt request not gated by enables");
  mon_idle_a: assert property ( // RULE_14
    s_r.mode == OSC_IDLE |-> !monitorOutPin)
    else $error("monitor active while idle");
  halted_a: assert property ( // RULE_25
    !s_r.blockEn |-> s_r.mode == OSC_IDLE)
    else $error("running while channel disabled");
  one_run_a: assert property ( // RULE_26
    trgWr && s_r.mode != OSC_IDLE |=> s_r.mode == $past(s_r.mode) || s_r.mode == OSC_IDLE)
    else $error("start taken during an active run");
  trg_status_a: assert property ( // RULE_24
    busRd && busAddr == `RFO_TRG_IDX |=>
    (busRdata[2:0] != 3'h0) == ($past(s_r.mode) != OSC_IDLE))
    else $error("trigger read does not show the run state");
  mc_count_a: assert property ( // RULE_01
    running && oscRise && !busWr |=> s_r.mc == $past(s_r.mc) + 24'h000001)
    else $error("measurement counter did not step");
  mc_hold_a: assert property ( // RULE_15
    !oscRise && !busWr |=> $stable(s_r.mc))
    else $error("measurement counter moved without an osc edge");
  tc_up_a: assert property ( // RULE_02
    running && s_r.mode == OSC_REF && tbRise && !busWr |=>
    s_r.tc == $past(s_r.tc) + 24'h000001)
    else $error("time base did not count up");
  tc_down_a: assert property ( // RULE_03
    running && s_r.mode != OSC_REF && tbRise && !busWr |=>
    s_r.tc == $past(s_r.tc) - 24'h000001)
    else $error("time base did not count down");
  sens_start_a: assert property ( // RULE_08
    trgWr && busWdata[2:0] == 3'h2 && s_r.mode == OSC_IDLE && s_r.blockEn
    |=> s_r.mode == OSC_SNA && s_r.mc == 24'h000000)
    else $error("sensor A start not taken");
  sens_stop_a: assert property ( // RULE_09
    (s_r.mode == OSC_SNA || s_r.mode == OSC_SNB) && !s_r.freeRun && (mcWrap || tcZero)
    |=> s_r.mode == OSC_IDLE)
    else $error("sensor run did not stop");
  ref_stop_a: assert property ( // RULE_05
    s_r.mode == OSC_REF && !s_r.freeRun && (mcWrap || tcWrap) |=> s_r.mode == OSC_IDLE)
    else $error("reference run did not stop");
  sens_abort_a: assert property ( // RULE_12
    s_r.mode == OSC_SNA && trgWr && !busWdata[`RFO_TRG_SNA_BIT] |=> s_r.mode == OSC_IDLE)
    else $error("sensor A abort not taken");
  free_flag_a: assert property ( // RULE_13
    s_r.freeRun |=> (s_r.flags & ~$past(s_r.flags)) == 5'h00)
    else $error("flag raised during free run");

  ref_done_c:  cover property (s_r.mode == OSC_REF ##1 s_r.flags[`RFO_F_REF]);
  sens_done_c: cover property (s_r.mode == OSC_SNB ##1 s_r.flags[`RFO_F_SNB]);
  abort_c:     cover property (s_r.mode == OSC_SNA && trgWr ##1 s_r.mode == OSC_IDLE);
  free_run_c:  cover property (s_r.freeRun && s_r.mode != OSC_IDLE && mcWrap);
  ac_sens_c:   cover property (s_r.oscMode == `RFO_MODE_AC && s_r.mode == OSC_SNA);

endmodule // rfo_converter

// >>> core/rfo_defines.svh
// constants of the oscillation counter converter: register indices, field positions, resets
// assumes inclusion by the package and the bench top module only
`ifndef RFO_DEFINES_SVH
`define RFO_DEFINES_SVH

// register indices on the plain register port
`define RFO_ADDR_W      3
`define RFO_CTL_IDX     3'h0
`define RFO_TRG_IDX     3'h1
`define RFO_FLAG_IDX    3'h2
`define RFO_EN_IDX      3'h3
`define RFO_MCL_IDX     3'h4
`define RFO_MCH_IDX     3'h5
`define RFO_TBL_IDX     3'h6
`define RFO_TBH_IDX     3'h7

// control register fields
`define RFO_CTL_EN_BIT    0
`define RFO_CTL_MODE_LSB  4
`define RFO_CTL_FREE_BIT  7
`define RFO_CTL_HALF_BIT  8
`define RFO_MODE_AC       2'h1

// trigger register fields
`define RFO_TRG_REF_BIT   0
`define RFO_TRG_SNA_BIT   1
`define RFO_TRG_SNB_BIT   2

// flag and enable fields
`define RFO_F_REF   0
`define RFO_F_TOVF  1
`define RFO_F_SNA   2
`define RFO_F_SNB   3
`define RFO_F_MOVF  4
`define RFO_NFLAG   5

// widths and reset values
`define RFO_DATA_W    16
`define RFO_CNT_W     24
`define RFO_CNT_RST   24'h000000
`define RFO_FLAG_RST  5'h00

`endif

// >>> core/rfo_pkg.sv
// types of the oscillation counter converter
// assumes rfo_defines.svh is on the include path
package rfo_pkg;
  `include "rfo_defines.svh"

  typedef enum logic [1:0] {OSC_IDLE, OSC_REF, OSC_SNA, OSC_SNB} rfo_osc_e;

  typedef logic [`RFO_CNT_W-1:0] rfo_cnt_t;

  typedef struct packed {
    rfo_osc_e                 mode;
    rfo_cnt_t                 mc;
    rfo_cnt_t                 tc;
    logic [`RFO_NFLAG-1:0]    flags;
    logic [`RFO_NFLAG-1:0]    en;
    logic                     blockEn;
    logic [1:0]               oscMode;
    logic                     freeRun;
    logic                     monHalve;
    logic                     oscPrev;
    logic                     tbPrev;
    logic                     monDiv;
    logic                     monOut;
    logic                     irq;
    logic [`RFO_DATA_W-1:0]   rdata;
  } rfo_state_s;
endpackage

// >>> tb/rfo_sensor_model.sv
// far side of the converter: sensor network oscillation and time base clock sources
// assumes the bench calls the pulse tasks from one process, never two at once
`timescale 1ns/10ps
module rfo_sensor_model (
  input  wire logic mclk,
  output logic      oscClk,
  output logic      timebaseClk
);
  // both clocks rest low between bursts, nothing runs free
  initial
  begin
    oscClk = 1'b0;
    timebaseClk = 1'b0;
  end

  // n oscillation periods, high one mclk, low for lo mclk (lo > 1 is a slow network)
  task automatic oscPulse(input int n, input int lo);
    repeat (n)
    begin
      @(posedge mclk);
      oscClk <= 1'b1;
      @(posedge mclk);
      oscClk <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask

  // n time base periods, same shape
  task automatic tbPulse(input int n, input int lo);
    repeat (n)
    begin
      @(posedge mclk);
      timebaseClk <= 1'b1;
      @(posedge mclk);
      timebaseClk <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask
endmodule // rfo_sensor_model

// >>> tb/rfo_converter_tb_top.sv
// self-checking bench of the converter core over its register port
// assumes the sensor model drives both counting clocks
`timescale 1ns/10ps
`include "rfo_defines.svh"
module rfo_converter_tb_top;
  import rfo_pkg::*;
  localparam logic [2:0] CTL = `RFO_CTL_IDX;
  localparam logic [2:0] TRG = `RFO_TRG_IDX;
  localparam logic [2:0] FLG = `RFO_FLAG_IDX;
  localparam logic [2:0] ENR = `RFO_EN_IDX;
  localparam logic [2:0] MCL = `RFO_MCL_IDX;
  localparam logic [2:0] TBL = `RFO_TBL_IDX;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  busAddr = 3'h0;
  logic [15:0] busWdata = 16'h0000;
  logic        busWr = 1'b0;
  logic        busRd = 1'b0;
  logic [15:0] busRdata;
  logic        oscClk;
  logic        timebaseClk;
  logic        monitorOutPin;
  logic        irqReq;
  logic        blockEnable;
  int          miscompares = 0;
  int          testsRun = 0;
  int          monRises = 0;
  // rows: index, write data, read-back value
  logic [34:0] rows [8] = '{{CTL, 16'hfffe, 16'h01b0}, {ENR, 16'hffff, 16'h001f},
    {MCL, 16'habcd, 16'habcd}, {3'h5, 16'hff12, 16'h0012}, {TBL, 16'h1234, 16'h1234},
    {3'h7, 16'hffab, 16'h00ab}, {FLG, 16'hffff, 16'h0000}, {TRG, 16'h0007, 16'h0000}};

  // 10 MHz clock
  always #50 mclk = ~mclk;
  // rising edges seen on the monitor pin
  always @(posedge monitorOutPin) monRises++;

  rfo_converter rfo_converter_i (.mclk(mclk), .rst_b(rst_b), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .oscClk(oscClk), .timebaseClk(timebaseClk), .monitorOutPin(monitorOutPin),
    .irqReq(irqReq), .blockEnable(blockEnable));
  rfo_sensor_model rfo_sensor_model_i (.mclk(mclk), .oscClk(oscClk),
    .timebaseClk(timebaseClk));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    testsRun++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge mclk);
    busWr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the cycle after
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge mclk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge mclk);
    busRd <= 1'b0;
    #1 chk(busRdata, e);
  endtask
  task automatic setC(input logic [2:0] lo, input logic [23:0] v);
    wr(lo, v[15:0]);
    wr(lo + 3'h1, {8'h00, v[23:16]});
  endtask
  task automatic rdC(input logic [2:0] lo, input logic [23:0] e);
    rd(lo, e[15:0]);
    rd(lo + 3'h1, {8'h00, e[23:16]});
  endtask
  // bounded wait for the interrupt request
  task automatic waitIrq();
    int k;
    k = 0;
    #1;
    while (irqReq !== 1'b1 && k < 40)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk({15'h0000, irqReq}, 16'h0001);
    if (irqReq !== 1'b1)
      give_verdict();
  endtask
  task automatic endT(input string s);
    $display("test %s done, mismatches %0d", s, miscompares);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    @(posedge mclk);
    #1 chk({busRdata[12:0], monitorOutPin, irqReq, blockEnable}, 16'h0000);
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(3'(i), 16'h0000);
    endT("reset");
    for (int i = 0; i < 8; i++)
    begin
      wr(rows[i][34:32], rows[i][31:16]);
      rd(rows[i][34:32], rows[i][15:0]);
    end
    endT("rows");
    wr(CTL, 16'h0001);
    #1 chk({15'h0000, blockEnable}, 16'h0001);
    wr(FLG, 16'h001f);
    setC(MCL, 24'hfffffd);
    setC(TBL, 24'h000000);
    wr(TRG, 16'h0001);
    rd(TRG, 16'h0001);
    rfo_sensor_model_i.tbPulse(5, 1);
    rfo_sensor_model_i.oscPulse(3, 2);
    waitIrq();
    rd(FLG, 16'h0001);
    rd(TRG, 16'h0000);
    rdC(MCL, 24'h000000);
    rdC(TBL, 24'h000005);
    endT("reference");
    wr(FLG, 16'h001f);
    wr(TRG, 16'h0002);
    wr(TRG, 16'h0003);
    rd(TRG, 16'h0002);
    rfo_sensor_model_i.oscPulse(7, 1);
    rfo_sensor_model_i.tbPulse(5, 3);
    waitIrq();
    rd(FLG, 16'h0004);
    rd(TRG, 16'h0000);
    rdC(MCL, 24'h000007);
    rdC(TBL, 24'h000000);
    endT("sensor a");
    wr(FLG, 16'h001f);
    wr(ENR, 16'h0017);
    setC(TBL, 24'h000003);
    wr(TRG, 16'h0004);
    rfo_sensor_model_i.tbPulse(3, 1);
    rd(FLG, 16'h0008);
    chk({15'h0000, irqReq}, 16'h0000);
    wr(ENR, 16'h001f);
    waitIrq();
    endT("sensor b");
    wr(FLG, 16'h001f);
    setC(MCL, 24'h000000);
    wr(TRG, 16'h0001);
    setC(TBL, 24'hffffff);
    rfo_sensor_model_i.tbPulse(1, 1);
    waitIrq();
    rd(FLG, 16'h0002);
    rd(TRG, 16'h0000);
    rdC(TBL, 24'h000000);
    wr(FLG, 16'h001f);
    setC(TBL, 24'h000010);
    wr(TRG, 16'h0002);
    setC(MCL, 24'hffffff);
    rfo_sensor_model_i.oscPulse(1, 1);
    waitIrq();
    rd(FLG, 16'h0010);
    rd(TRG, 16'h0000);
    rdC(TBL, 24'h000010);
    endT("overflows");
    wr(FLG, 16'h001f);
    setC(TBL, 24'h000009);
    wr(TRG, 16'h0002);
    rfo_sensor_model_i.oscPulse(2, 1);
    rfo_sensor_model_i.tbPulse(2, 1);
    wr(TRG, 16'h0000);
    rfo_sensor_model_i.oscPulse(3, 1);
    rfo_sensor_model_i.tbPulse(3, 1);
    rd(TRG, 16'h0000);
    rdC(MCL, 24'h000002);
    rdC(TBL, 24'h000007);
    rd(FLG, 16'h0000);
    setC(MCL, 24'h000000);
    setC(TBL, 24'h000009);
    wr(CTL, 16'h0011);
    wr(TRG, 16'h0004);
    rd(TRG, 16'h0000);
    wr(TRG, 16'h0002);
    rd(TRG, 16'h0002);
    wr(CTL, 16'h0010);
    rd(TRG, 16'h0000);
    chk({15'h0000, blockEnable}, 16'h0000);
    endT("abort and modes");
    wr(CTL, 16'h0081);
    setC(MCL, 24'hfffffe);
    setC(TBL, 24'h000000);
    wr(FLG, 16'h001f);
    wr(TRG, 16'h0001);
    monRises = 0;
    rfo_sensor_model_i.oscPulse(4, 1);
    rd(TRG, 16'h0001);
    rdC(MCL, 24'h000002);
    rdC(MCL, 24'h000002);
    chk(monRises[15:0], 16'h0004);
    wr(CTL, 16'h0181);
    rd(CTL, 16'h0181);
    monRises = 0;
    rfo_sensor_model_i.oscPulse(4, 3);
    rd(FLG, 16'h0000);
    chk(monRises[15:0], 16'h0002);
    wr(TRG, 16'h0000);
    rdC(MCL, 24'h000006);
    chk({15'h0000, monitorOutPin}, 16'h0000);
    endT("free run");
    give_verdict();
  end
endmodule // rfo_converter_tb_top
